//--- hdl/ptc_pkg.sv
// ptc_pkg: constants for the phy test control register block
//
// What this block does
// - bit 13 of the 10BASE-Te register lowers the receiver detect threshold when set.
// - bits 12:9 pick the squelch level, 200 mV at code 0 rising 50 mV per step to 600 mV at 8.
// - bit 7 set stops normal link pulses, clear lets them go out.
// - bit 4 reads one after inverted polarity is seen and is mirrored in the link status.
// - a 10BASE-Te register read clears polarity and its mirror; a link status read does not.
// - bit 0 set turns jabber off; it only matters in 10BASE-Te mode.
// - bits 15:8 of the first self-test register count errored checker bytes.
// - a one written to bit 15 of it latches the count for reading and clears the counter.
// - when the counter mode input is zero the count stops at 0xFF instead of wrapping.
// - bits 7:0 set the gap between self-test packets, default 0x7D for 500 bytes.
// - bits 10:0 set the self-test packet length, default 0x5EE for 1518 bytes.
// - the cable start bit begins a measurement and clears itself once done is set.
// - the cable done bit reads one when finished, zero while running, and resets to one.
// - the cable fail bit reads one when the measurement failed.
// - writing one to the software reset bit resets the whole transceiver and self-clears.
// - a one in the digital restart bit resets the logic, keeps registers, then self-clears.
package ptc_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [4:0] PTC_OFS_TENBASE = 5'h1a;
  localparam logic [4:0] PTC_OFS_ERRGAP  = 5'h1b;
  localparam logic [4:0] PTC_OFS_PKTLEN  = 5'h1c;
  localparam logic [4:0] PTC_OFS_CABLE   = 5'h1e;
  localparam logic [4:0] PTC_OFS_RSTCTL  = 5'h1f;
  localparam logic [4:0] PTC_OFS_LINKSTS = 5'h10;
  localparam logic [4:0] PTC_OFS_IRQSTS  = 5'h12;
  localparam logic [4:0] PTC_OFS_IRQEN   = 5'h13;
  localparam logic [4:0] PTC_OFS_IRQCLR  = 5'h14;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PTC_B_LOWTH    = 13;
  localparam int PTC_B_SQ_LO    = 9;
  localparam int PTC_B_NLPOFF   = 7;
  localparam int PTC_B_POL      = 4;
  localparam int PTC_B_JABOFF   = 0;
  localparam int PTC_B_LATCH    = 15;
  localparam int PTC_B_CSTART   = 15;
  localparam int PTC_B_CDONE    = 1;
  localparam int PTC_B_CFAIL    = 0;
  localparam int PTC_B_SWRST    = 15;
  localparam int PTC_B_DRST     = 14;
  localparam int PTC_B_LSTS_POL = 12;
  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [7:0]  PTC_GAP_RST   = 8'h7d;
  localparam logic [10:0] PTC_LEN_RST   = 11'h5ee;
  localparam logic [3:0]  PTC_SQ_MAX    = 4'h8;
  localparam logic [7:0]  PTC_CNT_MAX   = 8'hff;
  localparam logic [15:0] PTC_CABLE_RSV = 16'h0100;
  localparam int PTC_SQ_BASE_MV = 200;
  localparam int PTC_SQ_STEP_MV = 50;
  localparam int PTC_GAP_SCALE  = 4;
  // pulse widths of the reset requests
  localparam int PTC_RST_PULSE_NS = 300;
  localparam int PTC_CLK_NS       = 100;
  localparam logic [3:0] PTC_RST_CYC = 4'((PTC_RST_PULSE_NS + PTC_CLK_NS - 1) / PTC_CLK_NS);
  // interrupt bits
  localparam int PTC_IRQ_POL   = 0;
  localparam int PTC_IRQ_CDONE = 1;
  localparam int PTC_IRQ_CFAIL = 2;
  localparam int PTC_IRQ_ERR   = 3;
endpackage

//--- hdl/ptc_regs.sv
// ptc_regs: phy test control and status register bank
//
// The strobed register port is this design's own decision.
module ptc_regs
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // register port
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA,
  // receive front end status (pins, other domain)
  input  wire logic        POL_INV_IN,
  // self-test checker (core domain)
  input  wire logic        BIST_ERR_BYTE,
  input  wire logic        BIST_CNT_MODE,
  // cable engine (core domain)
  input  wire logic        CABLE_FINISH,
  input  wire logic        CABLE_FAILED,
  // controls to the analog and datapath
  output logic             RX_LOW_THRESH,
  output logic [3:0]       RX_SQUELCH,
  output logic [9:0]       RX_SQUELCH_MV,
  output logic             NLP_SUPPRESS,
  output logic             JABBER_OFF,
  output logic [7:0]       BIST_GAP,
  output logic [10:0]      BIST_GAP_BYTES,
  output logic [10:0]      BIST_PKT_LEN,
  output logic             CABLE_RUN,
  output logic             PHY_RESET_N,
  output logic             DIG_RESTART,
  output logic             LINK_POL_STS,
  // interrupt
  output logic             IRQ
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    PTC_CAB_IDLE = 2'b00,
    PTC_CAB_RUN  = 2'b01
  } ptc_cab_t;

  logic        pol_s1_r, pol_s2_r, pol_s3_r;
  logic        pol_sts_r, pol_nxt;
  logic        lowth_r, nlpoff_r, jaboff_r;
  logic [3:0]  sq_r;
  logic [7:0]  gap_r;
  logic [10:0] len_r;
  logic [7:0]  cnt_r, cnt_nxt, cnt_latch_r;
  ptc_cab_t    cab_r, cab_nxt;
  logic        cstart_r, cdone_r, cfail_r;
  logic [3:0]  swrst_cnt_r, drst_cnt_r;
  logic [3:0]  irq_sts_r, irq_en_r, irq_set;
  logic [15:0] rd_mux, rdata_r;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire wr_ten   = REG_WR && (REG_ADDR == PTC_OFS_TENBASE);
  wire wr_eg    = REG_WR && (REG_ADDR == PTC_OFS_ERRGAP);
  wire wr_len   = REG_WR && (REG_ADDR == PTC_OFS_PKTLEN);
  wire wr_cab   = REG_WR && (REG_ADDR == PTC_OFS_CABLE);
  wire wr_rst   = REG_WR && (REG_ADDR == PTC_OFS_RSTCTL);
  wire wr_ien   = REG_WR && (REG_ADDR == PTC_OFS_IRQEN);
  wire wr_iclr  = REG_WR && (REG_ADDR == PTC_OFS_IRQCLR);
  wire rd_ten   = REG_RD && (REG_ADDR == PTC_OFS_TENBASE);
  wire latch_wr = wr_eg && REG_WDATA[PTC_B_LATCH];
  wire cab_go   = wr_cab && REG_WDATA[PTC_B_CSTART];

  // ****************************************************************
  // polarity status: three-stage sync, agreement of stages 2 and 3
  // ****************************************************************
  wire pol_event = pol_s2_r && pol_s3_r && !pol_sts_r;
  always_comb begin
    pol_nxt = pol_sts_r;
    if (rd_ten) begin
      pol_nxt = 1'b0;
    end
    if (pol_s2_r && pol_s3_r) begin
      pol_nxt = 1'b1;
    end
  end
  // link status read (0x10) leaves the bit alone
  assign LINK_POL_STS = pol_sts_r;

  // ****************************************************************
  // self-test error counter
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    if (latch_wr) begin
      cnt_nxt = {7'h00, BIST_ERR_BYTE};
    end else if (BIST_ERR_BYTE) begin
      if (!BIST_CNT_MODE && cnt_r == PTC_CNT_MAX) begin
        cnt_nxt = cnt_r;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // cable diagnostic sequencer
  // ****************************************************************
  always_comb begin
    cab_nxt = cab_r;
    unique case (cab_r)
      PTC_CAB_IDLE: if (cab_go) cab_nxt = PTC_CAB_RUN;
      PTC_CAB_RUN:  if (CABLE_FINISH) cab_nxt = PTC_CAB_IDLE;
      default:      cab_nxt = PTC_CAB_IDLE;
    endcase
  end
  assign CABLE_RUN = cstart_r;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set = {
    (BIST_ERR_BYTE && !latch_wr),
    (cab_r == PTC_CAB_RUN && CABLE_FINISH && CABLE_FAILED),
    (cab_r == PTC_CAB_RUN && CABLE_FINISH),
    pol_event
  };
  assign IRQ = |(irq_sts_r & irq_en_r);

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rd_mux = 16'h0000;
    unique case (REG_ADDR)
      PTC_OFS_TENBASE: begin
        rd_mux[PTC_B_LOWTH]            = lowth_r;
        rd_mux[PTC_B_SQ_LO +: 4]       = sq_r;
        rd_mux[PTC_B_NLPOFF]           = nlpoff_r;
        rd_mux[PTC_B_POL]              = pol_sts_r;
        rd_mux[PTC_B_JABOFF]           = jaboff_r;
      end
      PTC_OFS_ERRGAP:  rd_mux = {cnt_latch_r, gap_r};
      PTC_OFS_PKTLEN:  rd_mux = {5'h00, len_r};
      PTC_OFS_CABLE: begin
        rd_mux = PTC_CABLE_RSV;
        rd_mux[PTC_B_CSTART]           = cstart_r;
        rd_mux[PTC_B_CDONE]            = cdone_r;
        rd_mux[PTC_B_CFAIL]            = cfail_r;
      end
      PTC_OFS_RSTCTL: begin
        rd_mux[PTC_B_SWRST]            = (swrst_cnt_r != 4'h0);
        rd_mux[PTC_B_DRST]             = (drst_cnt_r != 4'h0);
      end
      PTC_OFS_LINKSTS: rd_mux[PTC_B_LSTS_POL] = pol_sts_r;
      PTC_OFS_IRQSTS:  rd_mux = {12'h000, irq_sts_r};
      PTC_OFS_IRQEN:   rd_mux = {12'h000, irq_en_r};
      default:         rd_mux = 16'h0000;
    endcase
  end
  assign REG_RDATA = rdata_r;

  // ****************************************************************
  // outputs to the analog and datapath
  // ****************************************************************
  assign RX_LOW_THRESH  = lowth_r;
  assign RX_SQUELCH     = sq_r;
  assign RX_SQUELCH_MV  = (sq_r > PTC_SQ_MAX) ? 10'(PTC_SQ_BASE_MV)
                        : 10'(PTC_SQ_BASE_MV + PTC_SQ_STEP_MV * int'(sq_r));
  assign NLP_SUPPRESS   = nlpoff_r;
  assign JABBER_OFF     = jaboff_r;
  assign BIST_GAP       = gap_r;
  assign BIST_GAP_BYTES = 11'(PTC_GAP_SCALE * int'(gap_r));
  assign BIST_PKT_LEN   = len_r;
  assign PHY_RESET_N    = (swrst_cnt_r == 4'h0);
  assign DIG_RESTART    = (drst_cnt_r != 4'h0);

  // ****************************************************************
  // flops: whole register bank, cleared by pin reset and, except the polarity sync stages, by software reset
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pol_s1_r    <= 1'b0;
      pol_s2_r    <= 1'b0;
      pol_s3_r    <= 1'b0;
      pol_sts_r   <= 1'b0;
      lowth_r     <= 1'b0;
      sq_r        <= 4'h0;
      nlpoff_r    <= 1'b0;
      jaboff_r    <= 1'b0;
      gap_r       <= PTC_GAP_RST;
      len_r       <= PTC_LEN_RST;
      cnt_r       <= 8'h00;
      cnt_latch_r <= 8'h00;
      cab_r       <= PTC_CAB_IDLE;
      cstart_r    <= 1'b0;
      cdone_r     <= 1'b1;
      cfail_r     <= 1'b0;
      swrst_cnt_r <= 4'h0;
      drst_cnt_r  <= 4'h0;
      irq_sts_r   <= 4'h0;
      irq_en_r    <= 4'h0;
      rdata_r     <= 16'h0000;
    end else if (swrst_cnt_r == 4'h1) begin
      // last cycle of software reset: return everything but the polarity sync stages to defaults
      pol_sts_r   <= 1'b0;
      lowth_r     <= 1'b0;
      sq_r        <= 4'h0;
      nlpoff_r    <= 1'b0;
      jaboff_r    <= 1'b0;
      gap_r       <= PTC_GAP_RST;
      len_r       <= PTC_LEN_RST;
      cnt_r       <= 8'h00;
      cnt_latch_r <= 8'h00;
      cab_r       <= PTC_CAB_IDLE;
      cstart_r    <= 1'b0;
      cdone_r     <= 1'b1;
      cfail_r     <= 1'b0;
      swrst_cnt_r <= 4'h0;
      drst_cnt_r  <= 4'h0;
      irq_sts_r   <= 4'h0;
      irq_en_r    <= 4'h0;
      rdata_r     <= 16'h0000;
    end else begin
      pol_s1_r  <= POL_INV_IN;
      pol_s2_r  <= pol_s1_r;
      pol_s3_r  <= pol_s2_r;
      pol_sts_r <= pol_nxt;
      rdata_r   <= REG_RD ? rd_mux : 16'h0000;
      if (wr_ten) begin
        lowth_r  <= REG_WDATA[PTC_B_LOWTH];
        sq_r     <= REG_WDATA[PTC_B_SQ_LO +: 4];
        nlpoff_r <= REG_WDATA[PTC_B_NLPOFF];
        jaboff_r <= REG_WDATA[PTC_B_JABOFF];
      end
      if (wr_eg) begin
        gap_r <= REG_WDATA[7:0];
      end
      if (wr_len) begin
        len_r <= REG_WDATA[10:0];
      end
      if (latch_wr) begin
        cnt_latch_r <= cnt_r;
      end
      // digital restart clears datapath state, registers stay
      cnt_r <= (drst_cnt_r != 4'h0) ? 8'h00 : cnt_nxt;
      cab_r <= (drst_cnt_r != 4'h0) ? PTC_CAB_IDLE : cab_nxt;
      if (cab_go && cab_r == PTC_CAB_IDLE) begin
        cstart_r <= 1'b1;
        cdone_r  <= 1'b0;
        cfail_r  <= 1'b0;
      end else if (cab_r == PTC_CAB_RUN && CABLE_FINISH) begin
        cstart_r <= 1'b0;
        cdone_r  <= 1'b1;
        cfail_r  <= CABLE_FAILED;
      end
      if (wr_rst && REG_WDATA[PTC_B_SWRST]) begin
        swrst_cnt_r <= PTC_RST_CYC;
      end else if (swrst_cnt_r != 4'h0) begin
        swrst_cnt_r <= swrst_cnt_r - 4'h1;
      end
      if (wr_rst && REG_WDATA[PTC_B_DRST]) begin
        drst_cnt_r <= PTC_RST_CYC;
      end else if (drst_cnt_r != 4'h0) begin
        drst_cnt_r <= drst_cnt_r - 4'h1;
      end
      if (wr_ien) begin
        irq_en_r <= REG_WDATA[3:0];
      end
      // set wins over clear
      irq_sts_r <= (irq_sts_r & ~(wr_iclr ? REG_WDATA[3:0] : 4'h0)) | irq_set;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence rd_ten_s;
    REG_RD && REG_ADDR == PTC_OFS_TENBASE && !(pol_s2_r && pol_s3_r) && swrst_cnt_r != 4'h1;
  endsequence
  // reset request pulses: three cycles active, then released
  sequence swrst_pulse_s;
    !PHY_RESET_N [*3] ##1 PHY_RESET_N;
  endsequence
  sequence drst_pulse_s;
    DIG_RESTART [*3] ##1 !DIG_RESTART;
  endsequence
  sequence cab_start_s;
    wr_cab && REG_WDATA[PTC_B_CSTART] && cab_r == PTC_CAB_IDLE && swrst_cnt_r != 4'h1;
  endsequence

  pol_rd_clear_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    rd_ten_s |=> !pol_sts_r && !LINK_POL_STS)
    else $error("polarity not cleared by read");
  pol_set_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    pol_s2_r && pol_s3_r && swrst_cnt_r != 4'h1 |=> pol_sts_r)
    else $error("polarity status not set");
  pol_sts_keep_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_RD && REG_ADDR == PTC_OFS_LINKSTS && pol_sts_r && swrst_cnt_r != 4'h1
    |=> pol_sts_r)
    else $error("link status read cleared polarity");
  cnt_sat_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    cnt_r == PTC_CNT_MAX && !BIST_CNT_MODE && !latch_wr && drst_cnt_r == 4'h0
    && swrst_cnt_r != 4'h1 |=> cnt_r == PTC_CNT_MAX)
    else $error("error count wrapped in saturate mode");
  cnt_latch_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    latch_wr && swrst_cnt_r != 4'h1 |=> cnt_latch_r == $past(cnt_r) && cnt_r <= 8'h01)
    else $error("counter latch or clear failed");
  cnt_inc_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    BIST_ERR_BYTE && !latch_wr && cnt_r != PTC_CNT_MAX && drst_cnt_r == 4'h0
    && swrst_cnt_r != 4'h1 |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("error byte not counted");
  cab_start_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    cab_start_s |=> cstart_r && !cdone_r && CABLE_RUN)
    else $error("cable start not taken");
  cab_done_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    cab_r == PTC_CAB_RUN && CABLE_FINISH && drst_cnt_r == 4'h0 && swrst_cnt_r != 4'h1
    |=> cdone_r && !cstart_r && cfail_r == $past(CABLE_FAILED))
    else $error("cable done not reported");
  swrst_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_rst && REG_WDATA[PTC_B_SWRST] && swrst_cnt_r == 4'h0
    |=> swrst_pulse_s ##0 (gap_r == PTC_GAP_RST && len_r == PTC_LEN_RST))
    else $error("software reset sequence wrong");
  drst_keep_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_rst && REG_WDATA[PTC_B_DRST] && !REG_WDATA[PTC_B_SWRST] && swrst_cnt_r == 4'h0
    |=> $stable(len_r) ##0 drst_pulse_s)
    else $error("digital restart wrong");
  lowth_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_ten && swrst_cnt_r != 4'h1 |=> RX_LOW_THRESH == $past(REG_WDATA[PTC_B_LOWTH]))
    else $error("threshold control not applied");
  sq_mv_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    RX_SQUELCH == PTC_SQ_MAX |-> RX_SQUELCH_MV == 10'h258)
    else $error("squelch top code not 600 mV");

  // field stores, squelch range, counter wrap, restart, cable, interrupt, read port
  sq_undef_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    RX_SQUELCH > PTC_SQ_MAX |-> RX_SQUELCH_MV == 10'(PTC_SQ_BASE_MV))
    else $error("undefined squelch code not at base level");
  sq_hold_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_ten && swrst_cnt_r != 4'h1 |=> RX_SQUELCH == $past(REG_WDATA[PTC_B_SQ_LO +: 4]))
    else $error("squelch code not stored");
  nlp_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_ten && swrst_cnt_r != 4'h1 |=> NLP_SUPPRESS == $past(REG_WDATA[PTC_B_NLPOFF]))
    else $error("link pulse control not applied");
  jab_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_ten && swrst_cnt_r != 4'h1 |=> JABBER_OFF == $past(REG_WDATA[PTC_B_JABOFF]))
    else $error("jabber control not applied");
  gap_wr_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_eg && swrst_cnt_r != 4'h1 |=> BIST_GAP == $past(REG_WDATA[7:0]))
    else $error("packet gap not stored");
  len_wr_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    wr_len && swrst_cnt_r != 4'h1 |=> BIST_PKT_LEN == $past(REG_WDATA[10:0]))
    else $error("packet length not stored");
  cnt_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    cnt_r == PTC_CNT_MAX && BIST_CNT_MODE && BIST_ERR_BYTE && !latch_wr && drst_cnt_r == 4'h0
    && swrst_cnt_r != 4'h1 |=> cnt_r == 8'h00)
    else $error("error count did not wrap in wrap mode");
  drst_clr_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    DIG_RESTART && swrst_cnt_r != 4'h1 |=> cnt_r == 8'h00 && cab_r == PTC_CAB_IDLE)
    else $error("digital restart left datapath state");
  cab_excl_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    cdone_r |-> !CABLE_RUN)
    else $error("cable start still set while done");
  link_rd_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    REG_RD && REG_ADDR == PTC_OFS_LINKSTS && swrst_cnt_r != 4'h1
    |=> REG_RDATA[PTC_B_LSTS_POL] == $past(pol_sts_r))
    else $error("link status polarity read wrong");
  irq_set_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (irq_set != 4'h0) && swrst_cnt_r != 4'h1 |=> (irq_sts_r & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");
  rdata_idle_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    !REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
endmodule

//--- tb/phy_test_control_registers_test.sv
// self-checking bench of the phy test control register bank
module phy_test_control_registers_test
  import ptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic [4:0]  reg_addr  = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        pol_inv   = 1'b0;
  logic        err_byte  = 1'b0;
  logic        cnt_mode  = 1'b1;
  logic        cab_fin   = 1'b0;
  logic        cab_fail  = 1'b0;
  logic [15:0] rdata;
  logic        low_th, nlp_off, jab_off, cab_run, phy_rst_n, dig_rst, pol_sts, irq;
  logic [3:0]  squelch;
  logic [9:0]  squelch_mv;
  logic [7:0]  gap;
  logic [10:0] gap_bytes, pkt_len;
  logic [15:0] v;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  always #50 core_clk = ~core_clk;

  ptc_regs i_ptc_regs (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .POL_INV_IN(pol_inv),
    .BIST_ERR_BYTE(err_byte), .BIST_CNT_MODE(cnt_mode), .CABLE_FINISH(cab_fin),
    .CABLE_FAILED(cab_fail), .RX_LOW_THRESH(low_th), .RX_SQUELCH(squelch),
    .RX_SQUELCH_MV(squelch_mv), .NLP_SUPPRESS(nlp_off), .JABBER_OFF(jab_off),
    .BIST_GAP(gap), .BIST_GAP_BYTES(gap_bytes), .BIST_PKT_LEN(pkt_len),
    .CABLE_RUN(cab_run), .PHY_RESET_N(phy_rst_n), .DIG_RESTART(dig_rst),
    .LINK_POL_STS(pol_sts), .IRQ(irq)
  );

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
    chk(name, exp, v);
  endtask

  // error byte input high for n cycles
  task automatic hold_err(input int n);
    @(posedge core_clk);
    err_byte <= 1'b1;
    repeat (n) @(posedge core_clk);
    err_byte <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults;
    rd_chk("gap reg", PTC_OFS_ERRGAP, {8'h00, PTC_GAP_RST});
    rd_chk("len reg", PTC_OFS_PKTLEN, {5'h00, PTC_LEN_RST});
    rd_chk("cable reg", PTC_OFS_CABLE, PTC_CABLE_RSV | 16'h0002);
    rd_chk("rst reg", PTC_OFS_RSTCTL, 16'h0000);
    rd_chk("tenbase reg", PTC_OFS_TENBASE, 16'h0000);
    chk("gap bytes", 16'h01f4, {5'h00, gap_bytes});
    chk("pkt len", {5'h00, PTC_LEN_RST}, {5'h00, pkt_len});
    wr(5'h05, 16'hffff);
    rd_chk("unmapped", 5'h05, 16'h0000);
  endtask

  task automatic t_tenbase;
    wr(PTC_OFS_TENBASE, 16'hffff);
    rd_chk("tenbase ro", PTC_OFS_TENBASE, 16'h3e81);
    wr(PTC_OFS_TENBASE, 16'h3081);
    rd_chk("tenbase rw", PTC_OFS_TENBASE, 16'h3081);
    chk("ctl pins on", 16'h0007, {13'h0000, low_th, nlp_off, jab_off});
    for (int c = 0; c <= 8; c++) begin
      wr(PTC_OFS_TENBASE, 16'(c << 9));
      @(negedge core_clk);
      chk("squelch code", 16'(c), {12'h000, squelch});
      chk("squelch mv", 16'(200 + 50 * c), {6'h00, squelch_mv});
    end
    chk("ctl pins off", 16'h0000, {13'h0000, low_th, nlp_off, jab_off});
    wr(PTC_OFS_TENBASE, 16'h1200);
    rd_chk("squelch undef", PTC_OFS_TENBASE, 16'h1200);
    chk("squelch mv undef", 16'h00c8, {6'h00, squelch_mv});
    wr(PTC_OFS_TENBASE, 16'h0000);
  endtask

  task automatic t_polarity;
    @(posedge core_clk);
    pol_inv <= 1'b1;
    repeat (8) @(posedge core_clk);
    pol_inv <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd_chk("link sts", PTC_OFS_LINKSTS, 16'h1000);
    chk("link pol", 16'h0001, {15'h0000, v[PTC_B_LSTS_POL]});
    chk("mirror kept", 16'h0001, {15'h0000, pol_sts});
    rd_chk("pol read", PTC_OFS_TENBASE, 16'h0010);
    chk("mirror clr", 16'h0000, {15'h0000, pol_sts});
    rd_chk("pol clr", PTC_OFS_TENBASE, 16'h0000);
  endtask

  task automatic t_errcnt;
    wr(PTC_OFS_ERRGAP, 16'h807d);
    hold_err(3);
    wr(PTC_OFS_ERRGAP, 16'h807d);
    rd_chk("err count", PTC_OFS_ERRGAP, 16'h037d);
    @(posedge core_clk);
    cnt_mode <= 1'b0;
    hold_err(300);
    rd_chk("err latched", PTC_OFS_ERRGAP, 16'h037d);
    wr(PTC_OFS_ERRGAP, 16'h807d);
    rd_chk("err sat", PTC_OFS_ERRGAP, 16'hff7d);
    @(posedge core_clk);
    cnt_mode <= 1'b1;
    hold_err(257);
    wr(PTC_OFS_ERRGAP, 16'h8040);
    rd_chk("err wrap", PTC_OFS_ERRGAP, 16'h0140);
    chk("gap bytes", 16'h0100, {5'h00, gap_bytes});
  endtask

  task automatic t_cable;
    rd_chk("irq sts old", PTC_OFS_IRQSTS, 16'h0009);
    wr(PTC_OFS_IRQCLR, 16'h000f);
    wr(PTC_OFS_IRQEN, 16'h0002);
    wr(PTC_OFS_CABLE, 16'h8000);
    rd_chk("cable run", PTC_OFS_CABLE, PTC_CABLE_RSV | 16'h8000);
    chk("run pin", 16'h0001, {15'h0000, cab_run});
    @(posedge core_clk);
    cab_fin  <= 1'b1;
    cab_fail <= 1'b1;
    @(posedge core_clk);
    cab_fin  <= 1'b0;
    cab_fail <= 1'b0;
    rd_chk("cable failed", PTC_OFS_CABLE, PTC_CABLE_RSV | 16'h0003);
    chk("irq on", 16'h0001, {15'h0000, irq});
    rd_chk("irq sts", PTC_OFS_IRQSTS, 16'h0006);
    wr(PTC_OFS_IRQEN, 16'h0000);
    @(negedge core_clk);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(PTC_OFS_IRQEN, 16'h0002);
    wr(PTC_OFS_IRQCLR, 16'h0002);
    @(negedge core_clk);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rd_chk("irq sts clr", PTC_OFS_IRQSTS, 16'h0004);
    wr(PTC_OFS_CABLE, 16'h8000);
    @(posedge core_clk);
    cab_fin <= 1'b1;
    @(posedge core_clk);
    cab_fin <= 1'b0;
    rd_chk("cable ok", PTC_OFS_CABLE, PTC_CABLE_RSV | 16'h0002);
    chk("run pin off", 16'h0000, {15'h0000, cab_run});
  endtask

  task automatic t_resets;
    wr(PTC_OFS_PKTLEN, 16'hffff);
    rd_chk("len ro", PTC_OFS_PKTLEN, 16'h07ff);
    wr(PTC_OFS_TENBASE, 16'h2000);
    wr(PTC_OFS_RSTCTL, 16'h4000);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      chk("restart pulse", 16'(i < 3), {15'h0000, dig_rst});
    end
    rd_chk("len kept", PTC_OFS_PKTLEN, 16'h07ff);
    rd_chk("restart clr", PTC_OFS_RSTCTL, 16'h0000);
    wr(PTC_OFS_RSTCTL, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      chk("reset pulse", 16'(i >= 3), {15'h0000, phy_rst_n});
    end
    rd_chk("len reset", PTC_OFS_PKTLEN, {5'h00, PTC_LEN_RST});
    rd_chk("tenbase reset", PTC_OFS_TENBASE, 16'h0000);
    rd_chk("swrst clr", PTC_OFS_RSTCTL, 16'h0000);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_defaults();
    t_tenbase();
    t_polarity();
    t_errcnt();
    t_cable();
    t_resets();
    end_of_test();
  end
endmodule
